// [pin_sync.sv]
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module pin_sync
   #(parameter int N = 3)
   (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic [N-1:0] i_pins,
   output logic [N-1:0] o_pins
   );

   typedef struct packed
   {
      logic [N-1:0] stage1;
      logic [N-1:0] stage2;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;

   // first stage feeds only the second
   always_comb
   begin
      next_s = s;
      next_s.stage1 = i_pins;
      next_s.stage2 = s.stage1;
   end

   // state register, pins idle high after reset
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         s <= '1;
      end
      else if (i_ce)
      begin
         s <= next_s;
      end
   end

   assign o_pins = s.stage2;

endmodule

// [spi_front_pkg.sv]
// shared constants and types of the serial register front end
package spi_front_pkg;

   // ****************************************************************
   // register numbers
   // ****************************************************************
   localparam logic [4:0] REG_FIFO_LAST = 5'h04;
   localparam logic [4:0] REG_EP_STALL = 5'h09;
   localparam logic [4:0] REG_PIN_CTL = 5'h11;
   localparam logic [4:0] REG_GPIO_LOW = 5'h14;
   localparam logic [4:0] REG_MODE = 5'h1b;
   localparam logic [4:0] REG_LAST = 5'h1f;

   // ****************************************************************
   // command byte fields
   // ****************************************************************
   localparam int CMD_ADDR_MSB = 7;
   localparam int CMD_ADDR_LSB = 3;
   localparam int CMD_DIR_BIT = 1;
   localparam int CMD_ACK_BIT = 0;

   // ****************************************************************
   // local register fields, masks and reset values
   // ****************************************************************
   localparam int EP_STALL_ACK_BIT = 6;
   localparam logic [7:0] EP_STALL_MASK = 8'h7f;
   localparam logic [7:0] EP_STALL_RESET = 8'h00;
   localparam int PIN_CTL_FDUP_BIT = 4;
   localparam logic [7:0] PIN_CTL_RESET = 8'h00;
   localparam int MODE_HOST_BIT = 0;
   localparam logic [7:0] MODE_MASK = 8'h11;
   localparam logic [7:0] MODE_RESET = 8'h00;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int MCLK_HZ = 125_000_000;
   localparam int SCLK_MAX_HZ = 26_000_000;
   localparam int WR_WORD_W = 13;

   // ****************************************************************
   // access phases
   // ****************************************************************
   typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_DATA} phase_t;

endpackage

// [spi_master_model.sv]
// serial master model standing on the far side of the link
`timescale 1ns/10ps
module spi_master_model
   (
   input wire logic i_mclk,
   input wire logic i_miso,
   input wire logic i_miso_oe,
   input wire logic i_dq,
   input wire logic i_dq_oe,
   output logic o_sclk,
   output logic o_ss_n,
   output logic o_dq
   );
   logic [7:0] tx [8];
   logic [7:0] rx [8];
   logic drv = 1'b0;
   // shared data line level: the slave wins while it drives
   assign o_dq = i_dq_oe ? i_dq : drv;
   initial
   begin
      o_sclk = 1'b0;
      o_ss_n = 1'b1;
   end
   // one access of nb whole bytes plus ex loose bits, 64 ns clock
   task automatic frame(input int nb, input int ex);
      o_ss_n <= 1'b0;
      repeat (4) @(posedge i_mclk);
      for (int i = 0; i < nb * 8 + ex; i++)
      begin
         drv <= tx[i / 8][7 - i % 8];
         repeat (4) @(posedge i_mclk);
         o_sclk <= 1'b1;
         repeat (2) @(posedge i_mclk);
         rx[i / 8][7 - i % 8] = i_miso_oe ? i_miso : o_dq; // mid high
         repeat (2) @(posedge i_mclk);
         o_sclk <= 1'b0;
      end
      repeat (4) @(posedge i_mclk);
      o_ss_n <= 1'b1;
      drv <= ~drv; // released line shows no stale bit
      repeat (8) @(posedge i_mclk);
   endtask
endmodule

// [spi_register_access_front_end.sv]
// serial slave front end giving an external master the register file
// Function
// - access is command byte then data bytes, all bits msb first
// - register number is the top five command bits, msb first
// - direction one writes the register, zero reads it back
// - ack flag sets stall-status ack bit in peripheral mode only
// - full duplex shifts eight status bits out during command byte
// - half duplex sends no status byte in command phase
// - registers zero to four hold the address for every byte
// - registers five to nineteen advance the address per byte
// - register twenty holds the address
// - registers 21 to 31 advance, stopping at register 31
// - bits without function read zero; master writes no ones
// - host-select bit in mode register selects host operation
// - 32 addresses, 26 peripheral and 23 host registers in use
// - peripheral status order: suspend down to ep0 in available
// - host status order: transfer done down to bus event
// - sample on clock rise, change on fall, clock at most 26 MHz
// - select low frames access; high ignores clock, output floats
// - half duplex floats data output, data line turns around
`timescale 1ns/10ps
module spi_register_access_front_end
   import spi_front_pkg::*;
   (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_sclk,
   input wire logic i_ss_n,
   input wire logic i_mosi,
   output logic o_mosi,
   output logic o_mosi_oe,
   output logic o_miso,
   output logic o_miso_oe,
   input wire logic [7:0] i_periph_status,
   input wire logic [7:0] i_host_status,
   output logic [4:0] o_reg_addr,
   output logic o_reg_rd,
   input wire logic [7:0] i_reg_rdata,
   output logic o_wr_valid,
   input wire logic i_wr_ready,
   output logic [4:0] o_wr_addr,
   output logic [7:0] o_wr_data,
   output logic o_host_mode,
   output logic o_full_duplex,
   output logic [7:0] o_endpoint_stall_status,
   output logic o_write_dropped
   );

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed
   {
      phase_t phase;
      logic [2:0] bit_cnt;
      logic [7:0] rx;
      logic [7:0] tx;
      logic [7:0] rd_hold;
      logic [4:0] addr;
      logic dir_write;
      logic fetch;
      logic drive;
      logic [7:0] endpoint_stall_status;
      logic [7:0] pin_ctl;
      logic [7:0] operating_mode_config;
      logic dropped;
      logic sclk_d;
      logic ss_d;
   } front_state_t;

   front_state_t s;
   front_state_t next_s;

   logic [2:0] pins_sync;
   logic sclk_s;
   logic ss_s;
   logic mosi_s;
   logic sclk_rise;
   logic sclk_fall;
   logic host;
   logic full_dup;
   logic [7:0] rx_byte;
   logic [7:0] status_byte;
   logic [7:0] read_byte;
   logic push_valid;
   logic push_ready;
   logic [WR_WORD_W-1:0] push_word;
   logic [WR_WORD_W-1:0] pop_word;

   // ****************************************************************
   // pin synchronisers and write buffer
   // ****************************************************************
   pin_sync #(.N(3)) u_sync
   (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .i_pins({i_sclk, i_ss_n, i_mosi}),
      .o_pins(pins_sync)
   );

   word_buf2 #(.W(WR_WORD_W)) u_wr_buf
   (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .i_valid(push_valid),
      .o_ready(push_ready),
      .i_data(push_word),
      .o_valid(o_wr_valid),
      .i_ready(i_wr_ready),
      .o_data(pop_word)
   );

   assign sclk_s = pins_sync[2];
   assign ss_s = pins_sync[1];
   assign mosi_s = pins_sync[0];

   // ****************************************************************
   // address sequencing
   // ****************************************************************
   // fifos, register twenty and the last register hold; rest advance
   function automatic logic [4:0] advance_addr(input logic [4:0] a);
      logic [4:0] r;
      r = a + 5'h01;
      if (a <= REG_FIFO_LAST)
      begin
         r = a;
      end
      if (a == REG_GPIO_LOW)
      begin
         r = a;
      end
      if (a == REG_LAST)
      begin
         r = a;
      end
      return r;
   endfunction

   // ****************************************************************
   // mode decode and read multiplexer
   // ****************************************************************
   // host bit picks register map and status layout
   assign host = s.operating_mode_config[MODE_HOST_BIT];
   assign full_dup = s.pin_ctl[PIN_CTL_FDUP_BIT];
   assign sclk_rise = sclk_s && !s.sclk_d;
   assign sclk_fall = !sclk_s && s.sclk_d;
   assign rx_byte = {s.rx[6:0], mosi_s};

   // status bits arrive already in link order, top bit first
   assign status_byte = host ? i_host_status : i_periph_status;

   // local registers answer here, all others come from the engine
   always_comb
   begin
      case (s.addr)
         REG_EP_STALL: read_byte = s.endpoint_stall_status & EP_STALL_MASK;
         REG_PIN_CTL: read_byte = s.pin_ctl;
         REG_MODE: read_byte = s.operating_mode_config & MODE_MASK;
         default: read_byte = i_reg_rdata;
      endcase
   end

   // ****************************************************************
   // serial engine
   // ****************************************************************
   // timing notes for users of this front end
   //  - every pin passes two flops, and edges are found one flop later,
   //    so a select fall or clock edge acts three system clocks after
   //    it reaches the pin
   //  - the serial clock must stay high and low for at least two
   //    system clocks each, or edges merge in the synchroniser
   //  - select must stay high at least three system clocks between
   //    accesses, or the next command byte starts late
   //  - the status byte is loaded the cycle select is seen low, so
   //    its top bit stands before the first clock rise arrives
   //  - the eighth rise of the command loads the address; a read then
   //    strobes the engine once and catches its byte a cycle later
   //  - the caught byte enters the shifter at the next falling clock,
   //    before the master samples the first data bit
   //  - reads prefetch: after each read byte the next address is
   //    fetched at once, so a fifo may give up one byte too many
   //    when the master stops early
   //  - a write leaves the shifter only once all eight bits are in;
   //    a byte cut short by select rising is thrown away
   //  - writes to the engine go through the two-word buffer; when it
   //    is full the byte is lost and the dropped flag stays set until
   //    the next select fall
   //  - the stall, pin-control and mode registers live here and are
   //    written in place, never pushed to the engine
   //  - an acknowledge in the command is applied before any data byte,
   //    so a data write to the stall register in the same access wins
   //  - in host mode the acknowledge flag is ignored
   //  - with the clock enable low every flop here holds, so pin edges
   //    that come and go meanwhile are missed
   //
   // one pass per clock: frame, shift in, decode, shift out
   always_comb
   begin
      next_s = s;
      next_s.fetch = 1'b0;
      next_s.sclk_d = sclk_s;
      next_s.ss_d = ss_s;
      push_valid = 1'b0;
      push_word = {s.addr, rx_byte};
      // read data is caught one cycle after the address settles
      if (s.fetch)
      begin
         next_s.rd_hold = read_byte;
      end
      if (ss_s)
      begin
         // deselected: clock ignored, partial byte thrown away
         next_s.phase = PH_IDLE;
         next_s.bit_cnt = 3'd0;
         next_s.drive = 1'b0;
      end
      else if (s.ss_d)
      begin
         // select just fell: a fresh command byte starts
         next_s.phase = PH_CMD;
         next_s.bit_cnt = 3'd0;
         next_s.dropped = 1'b0;
         next_s.tx = full_dup ? status_byte : 8'h00;
         next_s.drive = full_dup;
      end
      else
      begin
         if (sclk_rise && (s.phase != PH_IDLE))
         begin
            next_s.rx = rx_byte;
            next_s.bit_cnt = s.bit_cnt + 3'd1;
            if (s.bit_cnt == 3'd7)
            begin
               if (s.phase == PH_CMD)
               begin
                  // command complete: load address and direction
                  next_s.addr = rx_byte[CMD_ADDR_MSB:CMD_ADDR_LSB];
                  next_s.dir_write = rx_byte[CMD_DIR_BIT];
                  next_s.phase = PH_DATA;
                  next_s.fetch = !rx_byte[CMD_DIR_BIT];
                  if (rx_byte[CMD_ACK_BIT] && !host)
                  begin
                     next_s.endpoint_stall_status[EP_STALL_ACK_BIT] = 1'b1;
                  end
               end
               else
               begin
                  if (s.dir_write)
                  begin
                     // whole byte in: commit it
                     case (s.addr)
                        REG_EP_STALL:
                        begin
                           next_s.endpoint_stall_status =
                              rx_byte & EP_STALL_MASK;
                        end
                        REG_PIN_CTL:
                        begin
                           next_s.pin_ctl = rx_byte;
                        end
                        REG_MODE:
                        begin
                           next_s.operating_mode_config =
                              rx_byte & MODE_MASK;
                        end
                        default:
                        begin
                           push_valid = 1'b1;
                           next_s.dropped = s.dropped || !push_ready;
                        end
                     endcase
                  end
                  next_s.addr = advance_addr(s.addr);
                  next_s.fetch = !s.dir_write;
               end
            end
         end
         if (sclk_fall && (s.phase != PH_IDLE))
         begin
            // output changes only on the falling clock
            if (s.phase == PH_DATA)
            begin
               next_s.drive = full_dup || !s.dir_write;
            end
            if ((s.phase == PH_DATA) && (s.bit_cnt == 3'd0))
            begin
               next_s.tx = s.rd_hold;
            end
            else if (s.bit_cnt != 3'd0)
            begin
               next_s.tx = {s.tx[6:0], 1'b0};
            end
         end
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         s.phase <= PH_IDLE;
         s.bit_cnt <= 3'd0;
         s.rx <= 8'h00;
         s.tx <= 8'h00;
         s.rd_hold <= 8'h00;
         s.addr <= 5'h00;
         s.dir_write <= 1'b0;
         s.fetch <= 1'b0;
         s.drive <= 1'b0;
         s.endpoint_stall_status <= EP_STALL_RESET;
         s.pin_ctl <= PIN_CTL_RESET;
         s.operating_mode_config <= MODE_RESET;
         s.dropped <= 1'b0;
         s.sclk_d <= 1'b0;
         s.ss_d <= 1'b1;
      end
      else if (i_ce)
      begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // full duplex uses the dedicated output, half duplex the data line
   assign o_miso = s.tx[7];
   assign o_miso_oe = s.drive && full_dup;
   assign o_mosi = s.tx[7];
   assign o_mosi_oe = s.drive && !full_dup && (s.phase == PH_DATA)
                      && !s.dir_write;
   assign o_reg_addr = s.addr;
   assign o_reg_rd = s.fetch;
   assign o_wr_addr = pop_word[WR_WORD_W-1:8];
   assign o_wr_data = pop_word[7:0];
   assign o_host_mode = host;
   assign o_full_duplex = full_dup;
   assign o_endpoint_stall_status = s.endpoint_stall_status;
   assign o_write_dropped = s.dropped;

endmodule

// [spi_register_access_front_end_monitor.sv]
// assertion checker for the serial register front end
`timescale 1ns/10ps
module front_end_monitor
   (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_sclk,
   input wire logic i_ss_n,
   input wire logic i_wr_ready,
   input wire logic o_mosi_oe,
   input wire logic o_miso,
   input wire logic o_miso_oe,
   input wire logic o_reg_rd,
   input wire logic o_wr_valid,
   input wire logic [4:0] o_wr_addr,
   input wire logic [7:0] o_wr_data,
   input wire logic o_full_duplex,
   input wire logic [7:0] o_endpoint_stall_status
   );
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   // ******
   // link pins
   // ******
   a_miso_float: assert property (i_ss_n[*6] |-> !o_miso_oe)
      else $error("miso driven while deselected");
   a_half_miso: assert property ((!o_full_duplex)[*8] |-> !o_miso_oe)
      else $error("miso driven in half duplex");
   a_fdup_dq: assert property (o_full_duplex[*8] |-> !o_mosi_oe)
      else $error("data line driven in full duplex");
   a_status_oe: assert property (
      $fell(i_ss_n) && o_full_duplex |-> ##[2:5] o_miso_oe)
      else $error("status not driven after select");
   a_miso_edge: assert property (
      o_miso_oe && $past(o_miso_oe) && $changed(o_miso)
      |-> !$past(i_sclk, 2))
      else $error("miso changed outside low clock phase");
   // ******
   // engine side
   // ******
   a_rd_pulse: assert property (o_reg_rd |=> !o_reg_rd)
      else $error("read strobe longer than one cycle");
   a_wr_hold: assert property (o_wr_valid && !i_wr_ready |=>
      o_wr_valid && $stable(o_wr_addr) && $stable(o_wr_data))
      else $error("write word changed before taken");
   a_wr_rise: assert property ($rose(o_wr_valid) |-> $past(i_sclk, 2))
      else $error("write word not after clock rise");
   a_stall_top: assert property (!o_endpoint_stall_status[7])
      else $error("stall status top bit set");
endmodule
bind spi_register_access_front_end front_end_monitor mon_u (
   .i_mclk(i_mclk), .i_resetn(i_resetn), .i_sclk(i_sclk),
   .i_ss_n(i_ss_n), .i_wr_ready(i_wr_ready), .o_mosi_oe(o_mosi_oe),
   .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_reg_rd(o_reg_rd),
   .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr),
   .o_wr_data(o_wr_data), .o_full_duplex(o_full_duplex),
   .o_endpoint_stall_status(o_endpoint_stall_status));

// [tb_spi_register_access_front_end.sv]
// self-checking bench for the serial register front end
`timescale 1ns/10ps
module tb_spi_register_access_front_end;
   import spi_front_pkg::*;
   logic i_mclk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_wr_ready = 1'b1;
   logic [7:0] i_periph_status = 8'ha5;
   logic [7:0] i_host_status = 8'h3c;
   logic sclk, ss_n, dq, o_mosi, o_mosi_oe, o_miso, o_miso_oe;
   logic o_reg_rd, o_wr_valid, o_host_mode, o_full_duplex;
   logic o_write_dropped;
   logic [4:0] o_reg_addr, o_wr_addr;
   logic [7:0] o_wr_data, o_endpoint_stall_status, i_reg_rdata;
   logic [7:0] mem [32];
   logic [4:0] wa [$];
   logic [7:0] wd [$];
   int mismatches = 0;
   int total_checks = 0;
   // rows: start address and the addresses of its three words
   logic [4:0] row_a [5] = '{5'h02, 5'h05, 5'h13, 5'h1e, 5'h15};
   logic [4:0] row_e [5][3] = '{'{5'h02, 5'h02, 5'h02},
      '{5'h05, 5'h06, 5'h07}, '{5'h13, 5'h14, 5'h14},
      '{5'h1e, 5'h1f, 5'h1f}, '{5'h15, 5'h16, 5'h17}};
   always #4 i_mclk = ~i_mclk;
   spi_master_model mst (.i_mclk(i_mclk), .i_miso(o_miso),
      .i_miso_oe(o_miso_oe), .i_dq(o_mosi), .i_dq_oe(o_mosi_oe),
      .o_sclk(sclk), .o_ss_n(ss_n), .o_dq(dq));
   spi_register_access_front_end dut_u (.i_mclk(i_mclk),
      .i_resetn(i_resetn), .i_ce(1'b1), .i_sclk(sclk), .i_ss_n(ss_n),
      .i_mosi(dq), .o_mosi(o_mosi), .o_mosi_oe(o_mosi_oe),
      .o_miso(o_miso), .o_miso_oe(o_miso_oe),
      .i_periph_status(i_periph_status), .i_host_status(i_host_status),
      .o_reg_addr(o_reg_addr), .o_reg_rd(o_reg_rd),
      .i_reg_rdata(i_reg_rdata), .o_wr_valid(o_wr_valid),
      .i_wr_ready(i_wr_ready), .o_wr_addr(o_wr_addr),
      .o_wr_data(o_wr_data), .o_host_mode(o_host_mode),
      .o_full_duplex(o_full_duplex),
      .o_endpoint_stall_status(o_endpoint_stall_status),
      .o_write_dropped(o_write_dropped));
   // engine side: read data by address, log of taken words
   assign i_reg_rdata = mem[o_reg_addr];
   always @(posedge i_mclk)
   begin
      if (o_wr_valid === 1'b1 && i_wr_ready === 1'b1)
      begin
         wa.push_back(o_wr_addr);
         wd.push_back(o_wr_data);
      end
   end
   // compare and count
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one access: command c, data bytes d+1, d+2 ...
   task automatic acc(input logic [7:0] c, input logic [7:0] d,
      input int nb, input int ex);
      mst.tx[0] = c;
      for (int k = 1; k < 8; k++)
         mst.tx[k] = d + 8'(k);
      wa.delete();
      wd.delete();
      @(posedge i_mclk);
      mst.frame(nb, ex);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // watchdog
   initial
   begin
      #400000;
      mismatches++;
      end_sim();
   end
   // ******
   // main sequence
   // ******
   initial
   begin
      for (int i = 0; i < 32; i++)
         mem[i] = 8'(i * 7 + 3);
      repeat (5) @(posedge i_mclk);
      i_resetn <= 1'b1;
      @(posedge i_mclk);
      check("stall", o_endpoint_stall_status, 8'h00);
      check("mode", {6'h0, o_host_mode, o_full_duplex}, 8'h00);
      check("oe", {6'h0, o_miso_oe, o_mosi_oe}, 8'h00);
      $display("test reset done");
      for (int r = 0; r < 5; r++)
      begin
         acc({row_a[r], 3'b010}, 8'h40, 4, 0);
         check("echo", mst.rx[0], {row_a[r], 3'b010});
         check("words", 8'(wa.size()), 8'h03);
         for (int k = 0; k < 3; k++)
         begin
            check("waddr", 8'(wa[k]), 8'(row_e[r][k]));
            check("wdata", wd[k], 8'h41 + 8'(k));
         end
      end
      $display("test address walk done");
      acc(8'h4b, 8'h00, 1, 0);
      check("ack", o_endpoint_stall_status, 8'h40);
      acc(8'h4a, 8'hfe, 2, 0);
      check("unused", o_endpoint_stall_status, 8'h7f);
      acc(8'h4a, 8'hff, 2, 0);
      acc(8'h98, 8'h00, 3, 0);
      check("hd rd1", mst.rx[1], mem[19]);
      check("hd rd2", mst.rx[2], mem[20]);
      $display("test ack and half duplex done");
      acc(8'h8a, 8'h0f, 2, 0);
      check("fdup", {7'h0, o_full_duplex}, 8'h01);
      acc(8'h18, 8'h00, 3, 0);
      check("pstat", mst.rx[0], i_periph_status);
      check("fifo1", mst.rx[1], mem[3]);
      check("fifo2", mst.rx[2], mem[3]);
      acc(8'hda, 8'h00, 2, 0);
      check("host", {7'h0, o_host_mode}, 8'h01);
      acc(8'h99, 8'h00, 2, 0);
      check("hstat", mst.rx[0], i_host_status);
      check("noack", o_endpoint_stall_status, 8'h00);
      check("hrd", mst.rx[1], mem[19]);
      $display("test full duplex and host done");
      i_wr_ready <= 1'b0;
      acc(8'h02, 8'h20, 4, 0);
      check("drop", {7'h0, o_write_dropped}, 8'h01);
      check("held", 8'(wa.size()), 8'h00);
      i_wr_ready <= 1'b1;
      for (int k = 0; k < 20 && o_wr_valid !== 1'b0; k++)
         @(posedge i_mclk);
      check("drained", 8'(wa.size()), 8'h02);
      check("first", wd[0], 8'h21);
      check("second", wd[1], 8'h22);
      acc(8'h12, 8'h00, 1, 4);
      check("partial", 8'(wa.size()), 8'h00);
      $display("test stall and partial done");
      // reset in mid-run: back to peripheral half duplex
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_mclk);
      i_resetn <= 1'b1;
      @(posedge i_mclk);
      check("rst mode", {6'h0, o_host_mode, o_full_duplex}, 8'h00);
      check("rst drop", {7'h0, o_write_dropped}, 8'h00);
      repeat (3) @(posedge i_mclk);
      acc(8'h98, 8'h00, 2, 0);
      check("rst echo", mst.rx[0], 8'h98);
      check("rst rd", mst.rx[1], mem[19]);
      $display("test mid reset done");
      end_sim();
   end
endmodule

// [word_buf2.sv]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module word_buf2
   #(parameter int W = 13)
   (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [W-1:0] i_data,
   output logic o_valid,
   input wire logic i_ready,
   output logic [W-1:0] o_data
   );

   typedef struct packed
   {
      logic [1:0][W-1:0] mem;
      logic [1:0] count;
      logic rd_ptr;
   } buf_state_t;

   buf_state_t s;
   buf_state_t next_s;
   logic push;
   logic pop;

   // push at the tail, pop at the head
   always_comb
   begin
      next_s = s;
      push = i_valid && (s.count != 2'd2);
      pop = i_ready && (s.count != 2'd0);
      if (push)
      begin
         next_s.mem[s.rd_ptr ^ s.count[0]] = i_data;
      end
      if (pop)
      begin
         next_s.rd_ptr = ~s.rd_ptr;
      end
      next_s.count = s.count + {1'b0, push} - {1'b0, pop};
   end

   // state register
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         s <= '0;
      end
      else if (i_ce)
      begin
         s <= next_s;
      end
   end

   assign o_ready = (s.count != 2'd2);
   assign o_valid = (s.count != 2'd0);
   assign o_data = s.mem[s.rd_ptr];

endmodule
